/* File: core/vpt_pkg.sv */
// Constants, encodings and register map of the VLAN port tagging block.
// Assumes a single 250 MHz clock domain shared by MACs, fabric and CPU.
package vpt_pkg;

  // ----------------------------------------------------------------
  // VLAN identifiers
  // ----------------------------------------------------------------
  localparam int         VID_W       = 12;
  localparam int         VLAN_COUNT  = 4096;
  localparam logic [11:0] VID_NONE    = 12'h000;
  localparam logic [11:0] VID_MIN     = 12'h002;
  localparam logic [11:0] VID_MAX     = 12'hFFE;
  localparam logic [11:0] VID_DISCARD = 12'hFFF;
  localparam logic [11:0] PORT_DEFAULT_VLAN_ID_RST    = 12'h002;

  // ----------------------------------------------------------------
  // Modes, membership types and egress states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_GENERAL = 2'b00,
    MODE_ACCESS  = 2'b01,
    MODE_TRUNK   = 2'b10
  } vpt_mode_t;

  typedef enum logic [1:0] {
    MEM_EXCLUDE   = 2'b00,
    MEM_TAGGED    = 2'b01,
    MEM_UNTAGGED  = 2'b10,
    MEM_FORBIDDEN = 2'b11
  } vpt_memb_t;

  typedef enum logic [2:0] {
    EG_IDLE = 3'b000,
    EG_PASS = 3'b001,
    EG_INS  = 3'b010,
    EG_FCS  = 3'b011,
    EG_DROP = 3'b100
  } vpt_eg_state_t;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IF_SEL   = 8'h00;
  localparam logic [7:0] ADDR_IF_CFG   = 8'h04;
  localparam logic [7:0] ADDR_IF_PORT_DEFAULT_VLAN_ID  = 8'h08;
  localparam logic [7:0] ADDR_IF_NATV  = 8'h0C;
  localparam logic [7:0] ADDR_BUNDLE   = 8'h10;
  localparam logic [7:0] ADDR_VLAN_SEL = 8'h14;
  localparam logic [7:0] ADDR_VLAN_MEM = 8'h18;
  localparam logic [7:0] ADDR_VLAN_DYN = 8'h1C;
  localparam logic [7:0] ADDR_STATUS   = 8'h20;
  localparam logic [7:0] ADDR_DROPS    = 8'h24;

  localparam int CFG_MODE_LSB   = 0;
  localparam int CFG_ADMIT_BIT  = 2;
  localparam int CFG_FILT_BIT   = 3;
  localparam int CFG_NATIVE_BIT = 4;
  localparam int BND_EN_BIT     = 0;
  localparam int BND_ID_LSB     = 1;
  localparam int STAT_REJ_BIT   = 0;
  localparam int STAT_REF_BIT   = 1;

  // ----------------------------------------------------------------
  // Tag format and frame check sequence
  // ----------------------------------------------------------------
  localparam logic [7:0]  TPID_HI     = 8'h81;
  localparam logic [7:0]  TPID_LO     = 8'h00;
  localparam logic [3:0]  TCI_PRI_CFI = 4'h0;
  localparam logic [10:0] TAG_OFS     = 11'h00C;
  localparam logic [10:0] TAG_END     = 11'h00F;
  localparam logic [1:0]  LAST_OCTET  = 2'h3;
  localparam logic [31:0] CRC_INIT    = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY    = 32'hEDB88320;

endpackage

/* File: core/vpt_port_tagging.sv */
// VLAN classification at ingress and tag insertion/removal at egress.
// Assumes fabric frames arrive without FCS; one egress stream is shared.
//
// Operation
// - Untagged frames take the port default VLAN
// - Default VLAN writes outside 2..4094 rejected
// - VLAN 4095 frames are always dropped
// - Tagged-only ports drop untagged frames
// - Admit-all ports accept tagged and untagged
// - Ingress filter drops frames from non-members
// - Access port: one untagged VLAN only
// - Access port: frame type and filter fixed
// - General port: per-VLAN tagged or untagged
// - Trunk port: all tagged, optional native untagged
// - Trunk egress keeps frames tagged except an enabled native VLAN
// - Tagged member transmits frames with tag
// - Untagged member transmits frames without tag
// - Forbidden port is never a member
// - Excluded port may join through GVRP
// - Bundled port uses bundle membership; config refused
// - Insert or remove tag by egress port
//
// Strobed register access and the register addresses were left to the implementer.
module vpt_port_tagging
  import vpt_pkg::*;
#(
  parameter int NUM_PORTS   = 8,
  parameter int NUM_BUNDLES = 4,
  parameter int ADDR_W      = 8
) (
  input  wire logic                           sys_clk,
  input  wire logic                           reset,
  input  wire logic [ADDR_W-1:0]              regAddr,
  input  wire logic [31:0]                    regWdata,
  input  wire logic                           regWr,
  input  wire logic                           regRd,
  output logic      [31:0]                    regRdata,
  input  wire logic                           ingValid,
  input  wire logic [$clog2(NUM_PORTS)-1:0]   ingPort,
  input  wire logic                           ingTagged,
  input  wire logic [11:0]                    ingVid,
  output logic                                clsValid,
  output logic      [11:0]                    clsVid,
  output logic                                clsDrop,
  input  wire logic                           gvrpValid,
  input  wire logic [$clog2(NUM_PORTS+NUM_BUNDLES)-1:0] gvrpIf,
  input  wire logic [11:0]                    gvrpVid,
  input  wire logic                           gvrpJoin,
  input  wire logic                           egrValid,
  input  wire logic                           egrSop,
  input  wire logic                           egrEop,
  input  wire logic [7:0]                     egrData,
  input  wire logic [$clog2(NUM_PORTS)-1:0]   egrPort,
  input  wire logic [11:0]                    egrVid,
  input  wire logic                           egrHasTag,
  output logic                                egrReady,
  output logic                                outValid,
  output logic                                outSop,
  output logic                                outEop,
  output logic      [7:0]                     outData
);

  localparam int NUM_IF = NUM_PORTS + NUM_BUNDLES;
  localparam int IF_W   = $clog2(NUM_IF);
  localparam int PORT_W = $clog2(NUM_PORTS);
  localparam int BND_W  = $clog2(NUM_BUNDLES);

  // ----------------------------------------------------------------
  // Configuration storage
  // ----------------------------------------------------------------
  vpt_mode_t           ifMode     [NUM_IF];
  logic                ifAdmitTag [NUM_IF];
  logic                ifFilter   [NUM_IF];
  logic                ifNatEn    [NUM_IF];
  logic [11:0]         ifPvid     [NUM_IF];
  logic [11:0]         ifNative   [NUM_IF];
  logic                bndEn      [NUM_PORTS];
  logic [BND_W-1:0]    bndId      [NUM_PORTS];
  logic [2*NUM_IF-1:0] membTab    [VLAN_COUNT];
  logic [NUM_IF-1:0]   dynTab     [VLAN_COUNT];
  logic [IF_W-1:0]     ifSel_reg;
  logic [11:0]         vlanSel_reg;
  logic                rejected_reg;
  logic                refused_reg;
  logic [31:0]         drops_reg;

  // ----------------------------------------------------------------
  // Membership decoding
  // ----------------------------------------------------------------
  // A bundled port is replaced by its bundle's interface
  function automatic logic [IF_W-1:0] ifOf(input logic [PORT_W-1:0] p);
    if (bndEn[p]) begin
      ifOf = IF_W'(NUM_PORTS) + IF_W'(bndId[p]);
    end else begin
      ifOf = IF_W'(p);
    end
  endfunction

  function automatic vpt_memb_t membOf(input logic [IF_W-1:0] ifx,
                                       input logic [11:0]     vid);
    membOf = vpt_memb_t'(membTab[vid][2*ifx +: 2]);
  endfunction

  function automatic logic isMember(input logic [IF_W-1:0] ifx,
                                    input logic [11:0]     vid);
    vpt_memb_t m;
    m = membOf(ifx, vid);
    isMember = 1'b0;
    unique case (ifMode[ifx])
      MODE_ACCESS:  isMember = (vid == ifPvid[ifx]);
      MODE_TRUNK:   isMember = (m == MEM_TAGGED) || (m == MEM_UNTAGGED)
                     || (ifNatEn[ifx] && vid == ifNative[ifx]
                         && m != MEM_FORBIDDEN);
      MODE_GENERAL: isMember = (m == MEM_TAGGED) || (m == MEM_UNTAGGED);
      default:      isMember = 1'b0;
    endcase
    if (ifMode[ifx] != MODE_ACCESS && m == MEM_EXCLUDE && dynTab[vid][ifx]) begin
      isMember = 1'b1;
    end
    if (m == MEM_FORBIDDEN) begin
      isMember = 1'b0;
    end
  endfunction

  function automatic logic sendUntagged(input logic [IF_W-1:0] ifx,
                                        input logic [11:0]     vid);
    sendUntagged = 1'b0;
    unique case (ifMode[ifx])
      MODE_ACCESS:  sendUntagged = 1'b1;
      MODE_TRUNK:   sendUntagged = ifNatEn[ifx] && vid == ifNative[ifx];
      MODE_GENERAL: sendUntagged = membOf(ifx, vid) == MEM_UNTAGGED;
      default:      sendUntagged = 1'b0;
    endcase
  endfunction

  // Byte-wise reflected CRC-32 of the Ethernet frame check sequence
  function automatic logic [31:0] crcByte(input logic [31:0] c,
                                          input logic [7:0]  d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    crcByte = r;
  endfunction

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  logic                selBundled;
  logic [11:0]         wrVid;
  vpt_mode_t           wrMode;
  logic                rejectEv;
  logic                refuseEv;
  logic [2*NUM_IF-1:0] memRow;

  assign selBundled = (ifSel_reg < IF_W'(NUM_PORTS))
                      && bndEn[ifSel_reg[PORT_W-1:0]];
  assign wrVid      = regWdata[11:0];
  assign wrMode     = vpt_mode_t'(regWdata[CFG_MODE_LSB +: 2]);

  always_comb begin
    rejectEv = 1'b0;
    refuseEv = 1'b0;
    memRow   = regWdata[2*NUM_IF-1:0];
    if (regWr && !selBundled) begin
      if (regAddr == ADDR_IF_PORT_DEFAULT_VLAN_ID) begin
        rejectEv = (wrVid < VID_MIN) || (wrVid > VID_MAX);
      end
      if (regAddr == ADDR_IF_CFG) begin
        rejectEv = regWdata[CFG_MODE_LSB +: 2] == 2'b11;
      end
    end
    if (regWr && selBundled && (regAddr == ADDR_IF_CFG
        || regAddr == ADDR_IF_PORT_DEFAULT_VLAN_ID || regAddr == ADDR_IF_NATV)) begin
      refuseEv = 1'b1;
    end
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (bndEn[p]) begin
        memRow[2*p +: 2] = membTab[vlanSel_reg][2*p +: 2];
        if (regWr && regAddr == ADDR_VLAN_MEM
            && regWdata[2*p +: 2] != membTab[vlanSel_reg][2*p +: 2]) begin
          refuseEv = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ifSel_reg   <= '0;
      vlanSel_reg <= VID_MIN;
    end else if (regWr) begin
      if (regAddr == ADDR_IF_SEL) begin
        ifSel_reg <= regWdata[IF_W-1:0];
      end
      if (regAddr == ADDR_VLAN_SEL) begin
        vlanSel_reg <= wrVid;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_IF; i++) begin
        ifMode[i]     <= MODE_GENERAL;
        ifAdmitTag[i] <= 1'b0;
        ifFilter[i]   <= 1'b0;
        ifNatEn[i]    <= 1'b0;
        ifPvid[i]     <= PORT_DEFAULT_VLAN_ID_RST;
        ifNative[i]   <= PORT_DEFAULT_VLAN_ID_RST;
      end
    end else if (regWr && !rejectEv && !refuseEv) begin
      if (regAddr == ADDR_IF_CFG) begin
        ifMode[ifSel_reg]     <= wrMode;
        ifAdmitTag[ifSel_reg] <= regWdata[CFG_ADMIT_BIT];
        ifFilter[ifSel_reg]   <= regWdata[CFG_FILT_BIT];
        ifNatEn[ifSel_reg]    <= regWdata[CFG_NATIVE_BIT];
      end
      if (regAddr == ADDR_IF_PORT_DEFAULT_VLAN_ID) begin
        ifPvid[ifSel_reg] <= wrVid;
      end
      if (regAddr == ADDR_IF_NATV) begin
        ifNative[ifSel_reg] <= wrVid;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        bndEn[p] <= 1'b0;
        bndId[p] <= '0;
      end
    end else if (regWr && regAddr == ADDR_BUNDLE
                 && ifSel_reg < IF_W'(NUM_PORTS)) begin
      bndEn[ifSel_reg[PORT_W-1:0]] <= regWdata[BND_EN_BIT];
      bndId[ifSel_reg[PORT_W-1:0]] <= regWdata[BND_ID_LSB +: BND_W];
    end
  end

  // Static table written by software, dynamic bits by GVRP
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int v = 0; v < VLAN_COUNT; v++) begin
        membTab[v] <= '0;
        dynTab[v]  <= '0;
      end
    end else begin
      if (regWr && regAddr == ADDR_VLAN_MEM) begin
        membTab[vlanSel_reg] <= memRow;
      end
      if (regWr && regAddr == ADDR_VLAN_DYN) begin
        dynTab[vlanSel_reg] <= '0;
      end
      if (gvrpValid && gvrpIf < IF_W'(NUM_IF)
          && membOf(gvrpIf, gvrpVid) == MEM_EXCLUDE) begin
        dynTab[gvrpVid][gvrpIf] <= gvrpJoin;
      end
    end
  end

  // Sticky flags: a new event wins over a write-one clear
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rejected_reg <= 1'b0;
      refused_reg  <= 1'b0;
    end else begin
      rejected_reg <= rejectEv || (rejected_reg && !(regWr
                      && regAddr == ADDR_STATUS && regWdata[STAT_REJ_BIT]));
      refused_reg  <= refuseEv || (refused_reg && !(regWr
                      && regAddr == ADDR_STATUS && regWdata[STAT_REF_BIT]));
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      regRdata <= '0;
    end else if (regRd) begin
      regRdata <= '0;
      unique case (regAddr)
        ADDR_IF_SEL:   regRdata[IF_W-1:0] <= ifSel_reg;
        ADDR_IF_CFG: begin
          regRdata[CFG_MODE_LSB +: 2] <= ifMode[ifSel_reg];
          regRdata[CFG_NATIVE_BIT]    <= ifNatEn[ifSel_reg];
          // Access ports show the fixed admit-all, filtering-on pair
          regRdata[CFG_ADMIT_BIT] <= ifMode[ifSel_reg] != MODE_ACCESS
                                     && ifAdmitTag[ifSel_reg];
          regRdata[CFG_FILT_BIT]  <= ifMode[ifSel_reg] == MODE_ACCESS
                                     || ifFilter[ifSel_reg];
        end
        ADDR_IF_PORT_DEFAULT_VLAN_ID:  regRdata[11:0] <= ifPvid[ifSel_reg];
        ADDR_IF_NATV:  regRdata[11:0] <= ifNative[ifSel_reg];
        ADDR_BUNDLE: begin
          regRdata[BND_EN_BIT]          <= bndEn[ifSel_reg[PORT_W-1:0]];
          regRdata[BND_ID_LSB +: BND_W] <= bndId[ifSel_reg[PORT_W-1:0]];
        end
        ADDR_VLAN_SEL: regRdata[11:0] <= vlanSel_reg;
        ADDR_VLAN_MEM: regRdata[2*NUM_IF-1:0] <= membTab[vlanSel_reg];
        ADDR_VLAN_DYN: regRdata[NUM_IF-1:0] <= dynTab[vlanSel_reg];
        ADDR_STATUS: begin
          regRdata[STAT_REJ_BIT] <= rejected_reg;
          regRdata[STAT_REF_BIT] <= refused_reg;
        end
        ADDR_DROPS:    regRdata <= drops_reg;
        default:       regRdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Ingress classification
  // ----------------------------------------------------------------
  logic [IF_W-1:0] ingIf;
  logic [11:0]     ingCls;
  logic            ingBad;

  always_comb begin
    ingIf  = ifOf(ingPort);
    ingCls = (ingTagged && ingVid != VID_NONE) ? ingVid : ifPvid[ingIf];
    ingBad = 1'b0;
    if (!ingTagged && ifMode[ingIf] != MODE_ACCESS && ifAdmitTag[ingIf]) begin
      ingBad = 1'b1;
    end
    if ((ifMode[ingIf] == MODE_ACCESS || ifFilter[ingIf])
        && !isMember(ingIf, ingCls)) begin
      ingBad = 1'b1;
    end
    if (ingCls == VID_DISCARD) begin
      ingBad = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      clsValid  <= 1'b0;
      clsVid    <= VID_NONE;
      clsDrop   <= 1'b0;
      drops_reg <= '0;
    end else begin
      clsValid <= ingValid;
      if (ingValid) begin
        clsVid  <= ingCls;
        clsDrop <= ingBad;
        if (ingBad) begin
          drops_reg <= drops_reg + 32'h00000001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Egress tagging
  // ----------------------------------------------------------------
  vpt_eg_state_t egSt_reg;
  logic [10:0]   idx_reg;
  logic [1:0]    oct_reg;
  logic [31:0]   crc_reg;
  logic          ins_reg;
  logic          strip_reg;
  logic [11:0]   vid_reg;
  logic [IF_W-1:0] egIf;
  logic          decDrop;
  logic          decIns;
  logic          decStrip;
  logic          curStrip;
  logic          take;
  logic [7:0]    tagByte;

  always_comb begin
    egIf     = ifOf(egrPort);
    decDrop  = egrVid == VID_DISCARD || !isMember(egIf, egrVid);
    decIns   = !egrHasTag && !sendUntagged(egIf, egrVid);
    decStrip = egrHasTag && sendUntagged(egIf, egrVid);
    curStrip = (egSt_reg == EG_IDLE) ? decStrip : strip_reg;
    egrReady = (egSt_reg == EG_IDLE) || (egSt_reg == EG_DROP)
               || (egSt_reg == EG_PASS && !(ins_reg && idx_reg == TAG_OFS));
    take     = egrValid && egrReady
               && (egSt_reg != EG_IDLE || (egrSop && !decDrop));
    unique case (oct_reg)
      2'h0:    tagByte = TPID_HI;
      2'h1:    tagByte = TPID_LO;
      2'h2:    tagByte = {TCI_PRI_CFI, vid_reg[11:8]};
      default: tagByte = vid_reg[7:0];
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      egSt_reg  <= EG_IDLE;
      idx_reg   <= '0;
      oct_reg   <= '0;
      ins_reg   <= 1'b0;
      strip_reg <= 1'b0;
      vid_reg   <= VID_NONE;
    end else begin
      unique case (egSt_reg)
        EG_IDLE: begin
          if (egrValid && egrSop) begin
            ins_reg   <= decIns;
            strip_reg <= decStrip;
            vid_reg   <= egrVid;
            idx_reg   <= 11'h001;
            if (decDrop) begin
              egSt_reg <= egrEop ? EG_IDLE : EG_DROP;
            end else begin
              egSt_reg <= egrEop ? EG_FCS : EG_PASS;
            end
          end
        end
        EG_PASS: begin
          if (ins_reg && idx_reg == TAG_OFS) begin
            egSt_reg <= EG_INS;
          end else if (take) begin
            idx_reg <= idx_reg + 11'h001;
            if (egrEop) begin
              egSt_reg <= EG_FCS;
            end
          end
        end
        EG_INS: begin
          oct_reg <= oct_reg + 2'h1;
          if (oct_reg == LAST_OCTET) begin
            ins_reg  <= 1'b0;
            egSt_reg <= EG_PASS;
          end
        end
        EG_FCS: begin
          oct_reg <= oct_reg + 2'h1;
          if (oct_reg == LAST_OCTET) begin
            egSt_reg <= EG_IDLE;
          end
        end
        EG_DROP: begin
          if (egrValid && egrEop) begin
            egSt_reg <= EG_IDLE;
          end
        end
        default: egSt_reg <= EG_IDLE;
      endcase
    end
  end

  // Output bytes and running frame check over what is actually sent
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      outValid <= 1'b0;
      outSop   <= 1'b0;
      outEop   <= 1'b0;
      outData  <= '0;
      crc_reg  <= CRC_INIT;
    end else begin
      outValid <= 1'b0;
      outSop   <= 1'b0;
      outEop   <= 1'b0;
      if (egSt_reg == EG_INS) begin
        outValid <= 1'b1;
        outData  <= tagByte;
        crc_reg  <= crcByte(crc_reg, tagByte);
      end else if (egSt_reg == EG_FCS) begin
        outValid <= 1'b1;
        outData  <= ~crc_reg[8*oct_reg +: 8];
        outEop   <= oct_reg == LAST_OCTET;
        if (oct_reg == LAST_OCTET) begin
          crc_reg <= CRC_INIT;
        end
      end else if (take) begin
        if (egSt_reg == EG_IDLE) begin
          outValid <= 1'b1;
          outSop   <= 1'b1;
          outData  <= egrData;
          crc_reg  <= crcByte(CRC_INIT, egrData);
        end else if (egSt_reg == EG_PASS && !(curStrip
                     && idx_reg >= TAG_OFS && idx_reg <= TAG_END)) begin
          outValid <= 1'b1;
          outData  <= egrData;
          crc_reg  <= crcByte(crc_reg, egrData);
        end
      end
    end
  end

endmodule

/* File: verif/vpt_port_tagging_chk.sv */
// Port assertions for the VLAN port tagging block.
// Assumes a bind onto vpt_port_tagging; one clock, async reset.
module vpt_chk
  import vpt_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        ingValid,
  input wire logic        ingTagged,
  input wire logic [11:0] ingVid,
  input wire logic        clsValid,
  input wire logic [11:0] clsVid,
  input wire logic        clsDrop,
  input wire logic        egrValid,
  input wire logic        egrSop,
  input wire logic        egrReady,
  input wire logic [11:0] egrVid,
  input wire logic        outValid,
  input wire logic        outSop,
  input wire logic        outEop
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Open frame on the MAC side; gaps inside a frame are legal
  logic inFrame;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      inFrame <= 1'b0;
    end else if (outValid) begin
      inFrame <= !outEop;
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_cls; ingValid |=> clsValid; endproperty
  a_cls: assert property (p_cls) else $error("no classify pulse");
  property p_nocls; !ingValid |=> !clsValid; endproperty
  a_nocls: assert property (p_nocls) else $error("stray pulse");
  property p_vid; ingValid && ingTagged && ingVid != 12'h000
    |=> clsVid == $past(ingVid); endproperty
  a_vid: assert property (p_vid) else $error("tag vid lost");
  property p_disc; ingValid && ingTagged && ingVid == VID_DISCARD
    |=> clsDrop; endproperty
  a_disc: assert property (p_disc) else $error("discard kept");
  property p_edrop; egrValid && egrReady && egrSop
    && egrVid == VID_DISCARD |=> !outValid; endproperty
  a_edrop: assert property (p_edrop) else $error("discard sent");
  property p_rdy; $fell(egrReady) |-> ##[1:5] egrReady; endproperty
  a_rdy: assert property (p_rdy) else $error("stall too long");
  property p_eop; outEop |-> outValid; endproperty
  a_eop: assert property (p_eop) else $error("eop without data");
  property p_sop; outValid && !inFrame |-> outSop; endproperty
  a_sop: assert property (p_sop) else $error("frame without sop");
endmodule

/* File: verif/vpt_mac_sink.sv */
// MAC side model: collects the transmitted bytes of one frame.
// Assumes the MAC never pushes back, as the egress stream requires.
module vpt_mac_sink (
  input wire logic       sys_clk,
  input wire logic       outValid,
  input wire logic       outEop,
  input wire logic [7:0] outData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q[$];
  logic       lastEop = 1'b0;
  always @(posedge sys_clk) begin
    if (outValid) begin
      q.push_back(outData);
      lastEop <= outEop;
    end
  end
endmodule

/* File: verif/vpt_port_tagging_tb_top.sv */
// Self-checking bench for the VLAN port tagging block.
// Assumes the sink model and the checker are compiled alongside.
module vpt_port_tagging_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import vpt_pkg::*;
  typedef struct {logic [31:0] cfg; logic t; logic [11:0] v, ev; logic ed;}
    vpt_row_t;
  logic sys_clk = 0, reset = 1, regWr = 0, regRd = 0, ingValid = 0;
  logic ingTagged = 0, egrValid = 0, egrSop = 0, egrEop = 0, egrHasTag = 0;
  logic [7:0] regAddr = '0, egrData = '0, outData;
  logic [31:0] regWdata = '0, regRdata;
  logic [2:0] ingPort = '0, egrPort = '0;
  logic [11:0] ingVid = '0, egrVid = '0, clsVid;
  logic clsValid, clsDrop, egrReady, outValid, outSop, outEop;
  logic gvrpValid = 0, gvrpJoin = 0;
  logic [3:0] gvrpIf = '0;
  logic [11:0] gvrpVid = '0;
  int nMismatch = 0, totalChecks = 0;
  vpt_row_t rows[8] = '{'{0,0,0,5,0}, '{0,1,7,7,0}, '{0,1,0,5,0},
    '{0,1,12'hFFF,12'hFFF,1}, '{32'hC,0,0,5,1}, '{32'hC,1,7,7,1},
    '{32'hC,1,5,5,0}, '{32'hD,0,0,5,0}};
  vpt_port_tagging u_dut (.sys_clk, .reset, .regAddr, .regWdata, .regWr,
    .regRd, .regRdata, .ingValid, .ingPort, .ingTagged, .ingVid, .clsValid,
    .clsVid, .clsDrop, .gvrpValid, .gvrpIf, .gvrpVid,
    .gvrpJoin, .egrValid, .egrSop, .egrEop, .egrData, .egrPort,
    .egrVid, .egrHasTag, .egrReady, .outValid, .outSop, .outEop, .outData);
  vpt_mac_sink u_mac (.sys_clk, .outValid, .outEop, .outData);
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // CRC register over a whole sent frame, its check sequence included
  function automatic logic [31:0] crcOf();
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    foreach (u_mac.q[i]) begin
      c = c ^ {24'h000000, u_mac.q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
    end
    return c;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    chk(regRdata, e);
    @(posedge sys_clk);
  endtask
  task automatic send(input logic [2:0] p, input logic [11:0] v,
                      input logic t, input int n);
    logic rdy;
    u_mac.q.delete();
    for (int i = 0; i < n; i++) begin
      egrValid <= 1'b1;
      egrSop <= (i == 0);
      egrEop <= (i == n - 1);
      egrData <= i[7:0];
      egrPort <= p;
      egrVid <= v;
      egrHasTag <= t;
      do begin
        @(negedge sys_clk);
        rdy = egrReady;
        @(posedge sys_clk);
      end while (!rdy);
    end
    egrValid <= 1'b0;
    repeat (12) @(posedge sys_clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rdchk(ADDR_IF_PORT_DEFAULT_VLAN_ID, {20'h0, PORT_DEFAULT_VLAN_ID_RST});
    wr(ADDR_IF_SEL, 32'h0);
    wr(ADDR_IF_PORT_DEFAULT_VLAN_ID, 32'h5);
    wr(ADDR_VLAN_SEL, 32'h5);
    wr(ADDR_VLAN_MEM, 32'h2);
    foreach (rows[k]) begin
      wr(ADDR_IF_CFG, rows[k].cfg);
      ingValid <= 1'b1;
      ingTagged <= rows[k].t;
      ingVid <= rows[k].v;
      @(posedge sys_clk);
      ingValid <= 1'b0;
      @(negedge sys_clk);
      chk(clsValid, 1);
      chk(clsDrop, rows[k].ed);
      if (!rows[k].ed) chk(clsVid, rows[k].ev);
      @(posedge sys_clk);
    end
    wr(ADDR_IF_PORT_DEFAULT_VLAN_ID, 32'hFFF);
    rdchk(ADDR_IF_PORT_DEFAULT_VLAN_ID, 32'h5);
    wr(ADDR_IF_PORT_DEFAULT_VLAN_ID, 32'hFFE);
    rdchk(ADDR_IF_PORT_DEFAULT_VLAN_ID, 32'hFFE);
    wr(ADDR_IF_PORT_DEFAULT_VLAN_ID, 32'h1);
    rdchk(ADDR_STATUS, 32'h1);
    wr(ADDR_STATUS, 32'h1);
    wr(ADDR_IF_PORT_DEFAULT_VLAN_ID, 32'h5);
    rdchk(8'h3C, 32'h0);
    wr(ADDR_IF_SEL, 32'h1);
    wr(ADDR_BUNDLE, 32'h1);
    wr(ADDR_IF_PORT_DEFAULT_VLAN_ID, 32'h9);
    rdchk(ADDR_IF_PORT_DEFAULT_VLAN_ID, {20'h0, PORT_DEFAULT_VLAN_ID_RST});
    rdchk(ADDR_STATUS, 32'h2);
    wr(ADDR_VLAN_SEL, 32'h7);
    wr(ADDR_VLAN_MEM, 32'h10);
    send(3'd2, 12'h007, 1'b0, 14);
    chk(u_mac.q.size(), 22);
    chk({u_mac.q[12], u_mac.q[13], u_mac.q[14], u_mac.q[15]}, 32'h81000007);
    chk(u_mac.q[16], 8'h0C);
    chk(u_mac.lastEop, 1);
    chk(crcOf(), 32'hDEBB20E3);
    send(3'd0, 12'h005, 1'b1, 20);
    chk(u_mac.q.size(), 20);
    chk(u_mac.q[12], 8'h10);
    chk(crcOf(), 32'hDEBB20E3);
    send(3'd0, VID_DISCARD, 1'b1, 18);
    chk(u_mac.q.size(), 0);
    wr(ADDR_IF_SEL, 32'h3);
    wr(ADDR_IF_CFG, 32'h2);
    gvrpValid <= 1'b1;
    gvrpIf <= 4'h3;
    gvrpVid <= 12'h005;
    gvrpJoin <= 1'b1;
    @(posedge sys_clk);
    gvrpValid <= 1'b0;
    send(3'd3, 12'h005, 1'b0, 13);
    chk(u_mac.q.size(), 21);
    chk(u_mac.q[15], 8'h05);
    rdchk(ADDR_DROPS, 32'h3);
    reset <= 1'b1;
    @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rdchk(ADDR_IF_CFG, 32'h0);
    rdchk(ADDR_DROPS, 32'h0);
    give_verdict();
  end
  // Whole sequence needs well under 2000 cycles
  initial begin
    #40000;
    nMismatch++;
    give_verdict();
  end
endmodule
bind vpt_port_tagging vpt_chk u_chk (.sys_clk, .reset, .ingValid,
  .ingTagged, .ingVid, .clsValid, .clsVid, .clsDrop, .egrValid, .egrSop,
  .egrReady, .egrVid, .outValid, .outSop, .outEop);
